// >>> hdl/nand_host_pkg.sv
// Package for the NAND host sequencer: opcodes, address counts, timing and carrier structs.
// Assumes a 40 MHz core clock and an 8-bit multiplexed asynchronous NAND device.
package nand_host_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int GLITCH_NS = 5;
   // Strobe low and high phases: at least one cycle, well above the glitch floor
   localparam int STROBE_CYC = ((GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                               ((GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
   localparam logic [3:0] CNT_ZERO = 4'h0;

   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_RESET = 8'hFF;
   localparam logic [7:0] OP_READ_ID = 8'h90;
   localparam logic [7:0] OP_PARAM_PAGE = 8'hEC;
   localparam logic [7:0] OP_UNIQUE_ID = 8'hED;
   localparam logic [7:0] OP_GET_FEAT = 8'hEE;
   localparam logic [7:0] OP_SET_FEAT = 8'hEF;
   localparam logic [7:0] OP_STATUS = 8'h70;
   localparam logic [7:0] OP_STATUS_ENH = 8'h78;
   localparam logic [7:0] OP_RAND_OUT = 8'h05;
   localparam logic [7:0] OP_RAND_OUT_CF = 8'hE0;
   localparam logic [7:0] OP_RAND_IN = 8'h85;
   localparam logic [7:0] OP_READ = 8'h00;
   localparam logic [7:0] OP_READ_CF = 8'h30;
   localparam logic [7:0] OP_COPY_CF = 8'h35;
   localparam logic [7:0] OP_PROG = 8'h80;
   localparam logic [7:0] OP_PROG_CF = 8'h10;
   localparam logic [7:0] OP_ERASE = 8'h60;
   localparam logic [7:0] OP_ERASE_CF = 8'hD0;
   localparam logic [7:0] OP_OTP_0 = 8'h29;
   localparam logic [7:0] OP_OTP_1 = 8'h17;
   localparam logic [7:0] OP_OTP_2 = 8'h04;
   localparam logic [7:0] OP_OTP_3 = 8'h19;

   // ------------------------------------------------------------
   // Cycle counts
   // ------------------------------------------------------------
   localparam logic [2:0] ADDR_FULL_2P = 3'h5;
   localparam logic [2:0] ADDR_FULL_1P = 3'h4;
   localparam logic [2:0] ADDR_ROW = 3'h3;
   localparam logic [2:0] ADDR_COL = 3'h2;
   localparam logic [2:0] ADDR_ONE = 3'h1;
   localparam logic [2:0] ADDR_NONE = 3'h0;
   localparam logic [2:0] FEAT_BYTES = 3'h4;

   // Operations the host sequencer can run
   typedef enum logic [3:0] {
      OPK_RESET, OPK_READ_MODE, OPK_PAGE_READ, OPK_COPY_READ, OPK_READ_ID, OPK_PARAM_PAGE,
      OPK_UNIQUE_ID, OPK_GET_FEAT, OPK_SET_FEAT, OPK_STATUS, OPK_STATUS_ENH, OPK_RAND_OUT,
      OPK_RAND_IN, OPK_PROGRAM, OPK_ERASE, OPK_OTP_ENTRY
   } op_kind_t;

   // Request from the user side
   typedef struct packed {
      op_kind_t kind;
      logic [39:0] addr;    // Bytes sent lowest first
      logic two_plane;      // Device is the two-plane variant
      logic extra_addr;     // Send the optional 5th address to a single-plane device
      logic multi_plane;    // Erase: chain a second 60h block address
      logic [23:0] addr2;   // Second row address for multiplane erase
      logic [11:0] out_len; // Bytes to read after the command, or to write for program and column input
   } op_req_t;

   // Pins driven toward the device
   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic read_strobe_n;
      logic wp_n;
   } nand_ctl_t;

endpackage

// >>> hdl/nand_host.sv
// Host-side NAND sequencer: drives the strobes and the shared 8-bit bus to run one command.
// Assumes the device's busy output and data bus are asynchronous pins; both pass two flops.
//
// Behaviour
// - Command byte: CE low, CLE high, ALE low, read strobe high; latched on WE rise.
// - Host holds write-protect high through command and address cycles of program/erase; wp_n here just follows write_enable.
// - Five address cycles on two-plane device, four on single-plane device.
// - Address byte: CE low, ALE high, CLE low, read strobe high; latched on WE rise.
// - Data input one byte per WE rise; latches low, read strobe high, write-protect high (wp_n here follows write_enable).
// - Device outputs one byte per read-strobe toggle with CE low, WE high, latches low.
// - Set-feature is EFh, one address, four data bytes; get-feature is EEh, one address.
// - Output column change: 05h, two column addresses, E0h.
// - Input column change: 85h, two column addresses, optional data; the sequencer here always writes at least one byte.
// - Page program: 80h, five addresses, data, then 10h.
// - Erase: 60h, three rows, D0h; multiplane chains 60h and three rows twice.
// - Copy read: 00h, five addresses, 35h; copy program uses 85h, five addresses, 10h; 85h here sends two column addresses and data, no 10h.
// - OTP entry is the bytes 29h, 17h, 04h, 19h with no data.
`timescale 1ns/1ps
module nand_host #(
   parameter int DATA_W = 8
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic req_valid,
   input wire nand_host_pkg::op_req_t req,
   input wire logic wr_valid,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic write_enable,
   input wire logic [DATA_W-1:0] io_in,
   input wire logic ready_busy_in,
   output nand_host_pkg::nand_ctl_t ctl,
   output logic [DATA_W-1:0] io_out,
   output logic io_oe_n,
   output logic req_ready,
   output logic wr_ready,
   output logic rd_valid,
   output logic [DATA_W-1:0] rd_data,
   output logic done
);

   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE, ST_CMD, ST_ADDR, ST_DATA_IN, ST_CMD2, ST_ADDR2, ST_CMD3, ST_WAIT_RB, ST_DATA_OUT, ST_DONE
   } state_t;

   // Pulse phases of one bus cycle
   typedef enum logic [1:0] {
      PH_SETUP, PH_LOW, PH_HIGH
   } phase_t;

   state_t state_r, state_nxt;
   phase_t phase_r, phase_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   nand_host_pkg::op_req_t req_r, req_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic [2:0] addr_n_r, addr_n_nxt;
   logic [11:0] out_left_r, out_left_nxt;
   logic [1:0] otp_idx_r, otp_idx_nxt;
   nand_host_pkg::nand_ctl_t ctl_nxt;
   logic [DATA_W-1:0] io_out_nxt;
   logic io_oe_n_nxt, req_ready_nxt, wr_ready_nxt, rd_valid_nxt, done_nxt;
   logic [DATA_W-1:0] rd_data_nxt;
   logic [DATA_W-1:0] io_s1_r, io_s2_r;
   logic rb_s1_r, rb_s2_r;

   // First opcode of each operation
   function automatic logic [7:0] first_op(input nand_host_pkg::op_kind_t k, input logic [1:0] otp);
      case (k)
         nand_host_pkg::OPK_RESET: first_op = nand_host_pkg::OP_RESET;
         nand_host_pkg::OPK_READ_ID: first_op = nand_host_pkg::OP_READ_ID;
         nand_host_pkg::OPK_PARAM_PAGE: first_op = nand_host_pkg::OP_PARAM_PAGE;
         nand_host_pkg::OPK_UNIQUE_ID: first_op = nand_host_pkg::OP_UNIQUE_ID;
         nand_host_pkg::OPK_GET_FEAT: first_op = nand_host_pkg::OP_GET_FEAT;
         nand_host_pkg::OPK_SET_FEAT: first_op = nand_host_pkg::OP_SET_FEAT;
         nand_host_pkg::OPK_STATUS: first_op = nand_host_pkg::OP_STATUS;
         nand_host_pkg::OPK_STATUS_ENH: first_op = nand_host_pkg::OP_STATUS_ENH;
         nand_host_pkg::OPK_RAND_OUT: first_op = nand_host_pkg::OP_RAND_OUT;
         nand_host_pkg::OPK_RAND_IN: first_op = nand_host_pkg::OP_RAND_IN;
         nand_host_pkg::OPK_PROGRAM: first_op = nand_host_pkg::OP_PROG;
         nand_host_pkg::OPK_ERASE: first_op = nand_host_pkg::OP_ERASE;
         nand_host_pkg::OPK_OTP_ENTRY: begin
            case (otp)
               2'h0: first_op = nand_host_pkg::OP_OTP_0;
               2'h1: first_op = nand_host_pkg::OP_OTP_1;
               2'h2: first_op = nand_host_pkg::OP_OTP_2;
               default: first_op = nand_host_pkg::OP_OTP_3;
            endcase
         end
         default: first_op = nand_host_pkg::OP_READ;
      endcase
   endfunction

   // Address cycles each operation needs
   function automatic logic [2:0] addr_count(input nand_host_pkg::op_req_t r);
      case (r.kind)
         nand_host_pkg::OPK_PAGE_READ, nand_host_pkg::OPK_COPY_READ, nand_host_pkg::OPK_PROGRAM: begin
            addr_count = (r.two_plane || r.extra_addr) ? nand_host_pkg::ADDR_FULL_2P : nand_host_pkg::ADDR_FULL_1P;
         end
         nand_host_pkg::OPK_READ_ID, nand_host_pkg::OPK_PARAM_PAGE, nand_host_pkg::OPK_UNIQUE_ID,
         nand_host_pkg::OPK_GET_FEAT, nand_host_pkg::OPK_SET_FEAT: addr_count = nand_host_pkg::ADDR_ONE;
         nand_host_pkg::OPK_STATUS_ENH, nand_host_pkg::OPK_ERASE: addr_count = nand_host_pkg::ADDR_ROW;
         nand_host_pkg::OPK_RAND_OUT, nand_host_pkg::OPK_RAND_IN: addr_count = nand_host_pkg::ADDR_COL;
         default: addr_count = nand_host_pkg::ADDR_NONE;
      endcase
   endfunction

   // Confirm opcode, where the operation has one
   function automatic logic [7:0] confirm_op(input nand_host_pkg::op_kind_t k);
      case (k)
         nand_host_pkg::OPK_PAGE_READ: confirm_op = nand_host_pkg::OP_READ_CF;
         nand_host_pkg::OPK_COPY_READ: confirm_op = nand_host_pkg::OP_COPY_CF;
         nand_host_pkg::OPK_RAND_OUT: confirm_op = nand_host_pkg::OP_RAND_OUT_CF;
         nand_host_pkg::OPK_PROGRAM: confirm_op = nand_host_pkg::OP_PROG_CF;
         default: confirm_op = nand_host_pkg::OP_ERASE_CF;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         io_s1_r <= '0;
         io_s2_r <= '0;
         rb_s1_r <= 1'b0;
         rb_s2_r <= 1'b0;
      end else if (clk_en) begin
         io_s1_r <= io_in;
         io_s2_r <= io_s1_r;
         rb_s1_r <= ready_busy_in;
         rb_s2_r <= rb_s1_r;
      end
   end

   // ------------------------------------------------------------
   // Sequencer next state
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      phase_nxt = phase_r;
      cnt_nxt = cnt_r;
      req_nxt = req_r;
      idx_nxt = idx_r;
      addr_n_nxt = addr_n_r;
      out_left_nxt = out_left_r;
      otp_idx_nxt = otp_idx_r;
      ctl_nxt = ctl;
      io_out_nxt = io_out;
      io_oe_n_nxt = 1'b1;
      req_ready_nxt = 1'b0;
      wr_ready_nxt = 1'b0;
      rd_valid_nxt = 1'b0;
      rd_data_nxt = rd_data;
      done_nxt = 1'b0;
      // Write-protect follows software every cycle, so it can toggle mid-operation
      ctl_nxt.wp_n = write_enable;
      case (state_r)
         ST_IDLE: begin
            ctl_nxt.ce_n = 1'b1;
            ctl_nxt.cle = 1'b0;
            ctl_nxt.ale = 1'b0;
            ctl_nxt.we_n = 1'b1;
            ctl_nxt.read_strobe_n = 1'b1;
            req_ready_nxt = 1'b1;
            if (req_valid && req_ready) begin
               req_nxt = req;
               addr_n_nxt = addr_count(req);
               otp_idx_nxt = 2'h0;
               out_left_nxt = req.out_len;
               req_ready_nxt = 1'b0;
               state_nxt = ST_CMD;
               phase_nxt = PH_SETUP;
            end
         end
         ST_CMD, ST_CMD2, ST_CMD3, ST_ADDR, ST_ADDR2, ST_DATA_IN: begin
            // One write cycle: setup, WE low, WE high; the low and high phases last STROBE_CNT cycles each
            ctl_nxt.ce_n = 1'b0;
            ctl_nxt.read_strobe_n = 1'b1;
            ctl_nxt.cle = (state_r == ST_CMD) || (state_r == ST_CMD2) || (state_r == ST_CMD3);
            ctl_nxt.ale = (state_r == ST_ADDR) || (state_r == ST_ADDR2);
            io_oe_n_nxt = 1'b0;
            case (state_r)
               ST_CMD: io_out_nxt = first_op(req_r.kind, otp_idx_r);
               ST_CMD2: io_out_nxt = (req_r.kind == nand_host_pkg::OPK_ERASE && idx_r == 3'h7) ?
                                     nand_host_pkg::OP_ERASE : confirm_op(req_r.kind);
               ST_CMD3: io_out_nxt = nand_host_pkg::OP_ERASE_CF;
               ST_ADDR: io_out_nxt = req_r.addr[8*idx_r +: 8];
               ST_ADDR2: io_out_nxt = req_r.addr2[8*idx_r +: 8];
               default: io_out_nxt = wr_data;
            endcase
            case (phase_r)
               PH_SETUP: begin
                  if (state_r == ST_DATA_IN) begin
                     // Stall until user supplies the byte
                     wr_ready_nxt = wr_valid && !wr_ready;
                     if (wr_valid && wr_ready) begin
                        phase_nxt = PH_LOW;
                        cnt_nxt = nand_host_pkg::STROBE_CNT;
                        ctl_nxt.we_n = 1'b0;
                        io_out_nxt = wr_data;
                        wr_ready_nxt = 1'b0;
                     end else begin
                        io_out_nxt = io_out;
                     end
                  end else begin
                     phase_nxt = PH_LOW;
                     cnt_nxt = nand_host_pkg::STROBE_CNT;
                     ctl_nxt.we_n = 1'b0;
                  end
               end
               PH_LOW: begin
                  io_out_nxt = io_out;
                  if (cnt_r > 4'h1) begin
                     cnt_nxt = cnt_r - 4'h1;
                  end else begin
                     ctl_nxt.we_n = 1'b1;
                     phase_nxt = PH_HIGH;
                     cnt_nxt = nand_host_pkg::STROBE_CNT;
                  end
               end
               default: begin
                  io_out_nxt = io_out;
                  if (cnt_r > 4'h1) begin
                     cnt_nxt = cnt_r - 4'h1;
                  end else begin
                     phase_nxt = PH_SETUP;
                     cnt_nxt = nand_host_pkg::CNT_ZERO;
                     // Sequence step after a finished write cycle
                     case (state_r)
                        ST_CMD: begin
                           idx_nxt = 3'h0;
                           if (req_r.kind == nand_host_pkg::OPK_OTP_ENTRY && otp_idx_r != 2'h3) begin
                              otp_idx_nxt = otp_idx_r + 2'h1;
                           end else if (addr_n_r != nand_host_pkg::ADDR_NONE) begin
                              state_nxt = ST_ADDR;
                           end else if (req_r.kind == nand_host_pkg::OPK_RESET) begin
                              state_nxt = ST_WAIT_RB;
                           end else if (req_r.kind == nand_host_pkg::OPK_STATUS) begin
                              state_nxt = ST_DATA_OUT;
                           end else begin
                              state_nxt = ST_DONE;
                           end
                        end
                        ST_ADDR: begin
                           if (idx_r + 3'h1 < addr_n_r) begin
                              idx_nxt = idx_r + 3'h1;
                           end else begin
                              idx_nxt = 3'h0;
                              case (req_r.kind)
                                 nand_host_pkg::OPK_SET_FEAT, nand_host_pkg::OPK_PROGRAM,
                                 nand_host_pkg::OPK_RAND_IN: state_nxt = ST_DATA_IN;
                                 nand_host_pkg::OPK_PAGE_READ, nand_host_pkg::OPK_COPY_READ,
                                 nand_host_pkg::OPK_RAND_OUT: state_nxt = ST_CMD2;
                                 nand_host_pkg::OPK_ERASE: begin
                                    state_nxt = ST_CMD2;
                                    if (req_r.multi_plane) begin
                                       idx_nxt = 3'h7; // Marks the chained 60h
                                    end
                                 end
                                 nand_host_pkg::OPK_GET_FEAT, nand_host_pkg::OPK_READ_ID,
                                 nand_host_pkg::OPK_PARAM_PAGE, nand_host_pkg::OPK_UNIQUE_ID: state_nxt = ST_WAIT_RB;
                                 default: state_nxt = ST_DATA_OUT;
                              endcase
                           end
                        end
                        ST_DATA_IN: begin
                           if (req_r.kind == nand_host_pkg::OPK_SET_FEAT && idx_r + 3'h1 == nand_host_pkg::FEAT_BYTES) begin
                              state_nxt = ST_WAIT_RB;
                           end else if (req_r.kind != nand_host_pkg::OPK_SET_FEAT && out_left_r <= 12'h1) begin
                              state_nxt = (req_r.kind == nand_host_pkg::OPK_PROGRAM) ? ST_CMD2 : ST_DONE;
                           end else begin
                              out_left_nxt = out_left_r - 12'h1;
                              idx_nxt = idx_r + 3'h1;
                           end
                        end
                        ST_CMD2: begin
                           if (idx_r == 3'h7) begin
                              idx_nxt = 3'h0;
                              state_nxt = ST_ADDR2;
                           end else if (req_r.kind == nand_host_pkg::OPK_RAND_OUT) begin
                              state_nxt = ST_DATA_OUT;
                           end else begin
                              state_nxt = ST_WAIT_RB;
                           end
                        end
                        ST_ADDR2: begin
                           if (idx_r + 3'h1 < nand_host_pkg::ADDR_ROW) begin
                              idx_nxt = idx_r + 3'h1;
                           end else begin
                              state_nxt = ST_CMD3;
                           end
                        end
                        default: state_nxt = ST_WAIT_RB;
                     endcase
                  end
               end
            endcase
         end
         ST_WAIT_RB: begin
            // Busy pin low while the device works; means nothing else is sent now
            ctl_nxt.cle = 1'b0;
            ctl_nxt.ale = 1'b0;
            if (cnt_r < 4'hF) begin
               cnt_nxt = cnt_r + 4'h1; // Let the device pull busy low first
            end else if (rb_s2_r) begin
               cnt_nxt = nand_host_pkg::CNT_ZERO;
               phase_nxt = PH_SETUP;
               state_nxt = (out_left_r != 12'h0 && req_r.kind != nand_host_pkg::OPK_PROGRAM &&
                            req_r.kind != nand_host_pkg::OPK_ERASE && req_r.kind != nand_host_pkg::OPK_SET_FEAT &&
                            req_r.kind != nand_host_pkg::OPK_RESET) ? ST_DATA_OUT : ST_DONE;
            end
         end
         ST_DATA_OUT: begin
            // One byte per read strobe; sample at the end of the low phase for sync delay
            ctl_nxt.ce_n = 1'b0;
            ctl_nxt.cle = 1'b0;
            ctl_nxt.ale = 1'b0;
            ctl_nxt.we_n = 1'b1;
            if (out_left_r == 12'h0) begin
               state_nxt = ST_DONE;
            end else if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
               if (cnt_r == 4'h1) begin
                  rd_valid_nxt = 1'b1;
                  rd_data_nxt = io_s2_r;
                  out_left_nxt = out_left_r - 12'h1;
                  ctl_nxt.read_strobe_n = 1'b1;
               end
            end else begin
               ctl_nxt.read_strobe_n = 1'b0;
               cnt_nxt = nand_host_pkg::STROBE_CNT + 4'h3;
            end
         end
         ST_DONE: begin
            done_nxt = 1'b1;
            ctl_nxt.cle = 1'b0; // No latch level left over after deselect
            ctl_nxt.ale = 1'b0;
            ctl_nxt.ce_n = 1'b1;
            state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Registers for the sequencer and every output
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
         phase_r <= PH_SETUP;
         cnt_r <= nand_host_pkg::CNT_ZERO;
         req_r <= '0;
         idx_r <= 3'h0;
         addr_n_r <= 3'h0;
         out_left_r <= 12'h0;
         otp_idx_r <= 2'h0;
         ctl <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1, wp_n: 1'b0};
         io_out <= '0;
         io_oe_n <= 1'b1;
         req_ready <= 1'b0;
         wr_ready <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= '0;
         done <= 1'b0;
      end else if (clk_en) begin
         state_r <= state_nxt;
         phase_r <= phase_nxt;
         cnt_r <= cnt_nxt;
         req_r <= req_nxt;
         idx_r <= idx_nxt;
         addr_n_r <= addr_n_nxt;
         out_left_r <= out_left_nxt;
         otp_idx_r <= otp_idx_nxt;
         ctl <= ctl_nxt;
         io_out <= io_out_nxt;
         io_oe_n <= io_oe_n_nxt;
         req_ready <= req_ready_nxt;
         wr_ready <= wr_ready_nxt;
         rd_valid <= rd_valid_nxt;
         rd_data <= rd_data_nxt;
         done <= done_nxt;
      end
   end

endmodule

// >>> verif/nand_host_properties.sv
// Assertions on the NAND host pins and request handshake.
// Bound to nand_host; assumes clk_en is held high.
`timescale 1ns/1ps
module nand_host_properties (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic write_enable,
   input wire nand_host_pkg::nand_ctl_t ctl,
   input wire logic io_oe_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // Pin levels per bus cycle; strobes last whole cycles, far above the glitch floor
   AST_CMD: assert property (ctl.cle |-> !ctl.ale && !ctl.ce_n && ctl.read_strobe_n)
      else $error("command cycle pins wrong");
   AST_ADDR: assert property (ctl.ale |-> !ctl.cle && !ctl.ce_n && ctl.read_strobe_n)
      else $error("address cycle pins wrong");
   AST_OUT: assert property (!ctl.read_strobe_n |-> ctl.we_n && !ctl.cle && !ctl.ale && !ctl.ce_n)
      else $error("read cycle pins wrong");
   AST_RE_GAP: assert property ($fell(ctl.read_strobe_n) |-> !ctl.read_strobe_n [*4] ##1 ctl.read_strobe_n)
      else $error("read strobe timing wrong");
   AST_WE_LEN: assert property ($fell(ctl.we_n) |=> $rose(ctl.we_n))
      else $error("write strobe width wrong");
   AST_WE_BUS: assert property (!ctl.we_n |-> !io_oe_n && !ctl.ce_n)
      else $error("bus not driven in write");
   AST_WP: assert property (!$past(srst) |-> ctl.wp_n == $past(write_enable))
      else $error("write protect not following");
   AST_TAKE: assert property (req_valid && req_ready |=> !req_ready [*2])
      else $error("request taken twice");
endmodule
bind nand_host nand_host_properties u_props (.core_clk(core_clk), .srst(srst), .req_valid(req_valid),
   .req_ready(req_ready), .write_enable(write_enable), .ctl(ctl), .io_oe_n(io_oe_n));

// >>> verif/nand_dev_model.sv
// Behavioural NAND device on the far side of the host sequencer.
// Assumes clk times the busy period and scrambles the released bus; bytes move on strobe edges.
`timescale 1ns/1ps
module nand_dev_model (
   input wire logic clk,
   input wire nand_host_pkg::nand_ctl_t ctl,
   input wire logic [7:0] io_out,
   input wire logic io_oe_n,
   output logic [7:0] io_in = 8'h00,
   output logic ready_busy_in
);
   logic [10:0] seen_q[$];
   logic stat_mode = 1'b0;
   logic [7:0] arr = 8'h5A;
   int busy = 0;
   int starts = 0;
   assign ready_busy_in = (busy == 0);
   // Latch on write strobe rise; extra address bytes are only logged
   always @(posedge ctl.we_n) begin
      if (!ctl.ce_n) begin
         seen_q.push_back({ctl.wp_n, ctl.cle, ctl.ale, io_out});
         if (ctl.cle && (busy == 0 || io_out inside {8'h70, 8'h78, 8'hFF})) begin
            stat_mode = io_out inside {8'h70, 8'h78};
            arr = 8'h5A;
            if (io_out inside {8'h10, 8'hD0} && ctl.wp_n) begin
               busy = 40;
               starts++;
            end
            if (io_out inside {8'h30, 8'h35}) busy = 20;
         end
      end
   end
   // One byte per falling read strobe
   always @(negedge ctl.read_strobe_n) begin
      if (!ctl.ce_n) begin
         io_in <= stat_mode ? 8'hC0 : arr;
         if (!stat_mode) arr = arr + 8'h01;
      end
   end
   // Released bus scrambles each cycle so a stale byte never looks valid
   always @(posedge clk) begin
      if (busy > 0) busy--;
      if (ctl.ce_n || !io_oe_n) io_in <= ~io_in;
   end
endmodule

// >>> verif/tb.sv
// Self-checking bench for the NAND host sequencer.
// Assumes the behavioural device in nand_dev_model.sv.
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic clk_en = 1'b1;
   logic req_valid = 1'b0;
   logic wr_valid = 1'b0;
   logic write_enable = 1'b1;
   logic [7:0] wr_data = 8'h00;
   nand_host_pkg::op_req_t req = '0;
   nand_host_pkg::nand_ctl_t ctl;
   logic [7:0] io_in, io_out, rd_data, lastc;
   logic ready_busy_in, io_oe_n, req_ready, wr_ready, rd_valid, done;
   logic [7:0] rd[$];
   int miscompares = 0;
   int num_checks = 0;
   // kind, first cmd, last cmd, cmd count, addr count, data count
   logic [39:0] tab[17] = '{40'h0490901100, 40'h05ECEC1100, 40'h06EDED1100, 40'h07EEEE1100,
      40'h08EFEF1104, 40'h0970701000, 40'h0A78781300, 40'h0B05E02200, 40'h0E60D02300, 40'h0200302500,
      40'h0200302400, 40'h0300352500, 40'h0100001000, 40'h0F29194000, 40'h0D80102502, 40'h0C85851202,
      40'h00FFFF1000};
   nand_host dut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .req_valid(req_valid), .req(req),
      .wr_valid(wr_valid), .wr_data(wr_data), .write_enable(write_enable), .io_in(io_in),
      .ready_busy_in(ready_busy_in), .ctl(ctl), .io_out(io_out), .io_oe_n(io_oe_n), .req_ready(req_ready),
      .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data), .done(done));
   nand_dev_model dev (.clk(core_clk), .ctl(ctl), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
      .ready_busy_in(ready_busy_in));
   initial forever #12.5 core_clk = ~core_clk;
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // One request end to end; a bound that runs out ends the run
   task automatic run(input logic [39:0] e, input logic [2:0] tp);
      int i;
      dev.seen_q.delete();
      rd.delete();
      req <= '{kind: nand_host_pkg::op_kind_t'(e[35:32]), addr: 40'h0504030201, two_plane: tp[0],
         extra_addr: tp[1], multi_plane: tp[2], addr2: 24'h0A0B0C, out_len: 12'h002};
      req_valid <= 1'b1;
      wr_valid <= 1'b1;
      for (i = 0; i < 3050; i++) begin
         @(posedge core_clk);
         if (req_valid && req_ready) req_valid <= 1'b0;
         if (rd_valid) rd.push_back(rd_data);
         if (wr_ready) wr_data <= wr_data + 8'h01;
         if (done) break;
      end
      if (i == 3050) begin
         miscompares++;
         final_report();
      end
   endtask
   // Every opcode family: command bytes, cycle counts and bytes read back
   task automatic t_table();
      int i, j, nc, na, nd;
      for (i = 0; i < 17; i++) begin
         run(tab[i], 3'(i != 10));
         nc = 0;
         na = 0;
         nd = 0;
         for (j = 0; j < dev.seen_q.size(); j++) begin
            if (dev.seen_q[j][9]) nc++;
            if (dev.seen_q[j][9]) lastc = dev.seen_q[j][7:0];
            if (dev.seen_q[j][8]) na++;
            if (dev.seen_q[j][9:8] == 2'b00) nd++;
         end
         chk("first cmd", {5'h0, dev.seen_q[0]}, {5'h0, 3'b110, tab[i][31:24]});
         chk("last cmd", {8'h0, lastc}, {8'h0, tab[i][23:16]});
         chk("cmd count", 16'(nc), 16'(tab[i][15:12]));
         chk("addr count", 16'(na), 16'(tab[i][11:8]));
         chk("data count", 16'(nd), 16'(tab[i][7:0]));
         for (j = 0; j < rd.size(); j++)
            chk("read byte", {8'h0, rd[j]},
               (tab[i][35:32] inside {4'h9, 4'hA}) ? 16'h00C0 : 16'(8'h5A + j));
      end
      $display("test opcode table done");
   endtask
   // Erase with protection low: wire shows it and the device never starts
   task automatic t_protect();
      int s;
      s = dev.starts;
      write_enable <= 1'b0;
      run(40'h0E60D02300, 3'h1);
      chk("protect on cmd", {15'h0, dev.seen_q[0][10]}, 16'h0000);
      chk("erase starts", 16'(dev.starts - s), 16'h0000);
      write_enable <= 1'b1;
      $display("test protect done");
   endtask
   // Dummy 5th address to a single-plane part; chained two-plane erase
   task automatic t_extra();
      run(40'h0200302500, 3'h2);
      chk("addr5", 16'(dev.seen_q.size()), 16'h0007);
      run(40'h0E60D02300, 3'h5);
      chk("erase2", {5'h0, dev.seen_q[4]}, 16'h0660);
      chk("row2", {5'h0, dev.seen_q[7]}, 16'h050A);
      $display("test extra done");
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      t_table();
      t_protect();
      t_extra();
      final_report();
   end
endmodule
